// file: design/dcr_pkg.sv
// ==================================================================
// Shared constants and types of the display command receiver
// ==================================================================
package dcr_pkg;

   // ===============================================================
   // Two-wire slave address
   // ===============================================================
   localparam logic [4:0] ADDR_FIXED_HI  = 5'h0f;  // Upper five bits
   localparam int         ADDR_W         = 7;

   // ===============================================================
   // Control and address byte layout
   // ===============================================================
   localparam int         CTRL_CONT_BIT  = 7;      // Continuation flag
   localparam int         CTRL_DCS_BIT   = 6;      // Data/command select
   localparam int         RW_BIT         = 0;      // Read when set

   // ===============================================================
   // Display text RAM geometry and fill value
   // ===============================================================
   localparam int         RAM_DEPTH      = 80;
   localparam int         AC_W           = 7;
   localparam logic [7:0] SPACE_CODE     = 8'h20;
   localparam logic [6:0] LINE1_LAST     = 7'h4f;
   localparam logic [6:0] LINE2A_LAST    = 7'h27;
   localparam logic [6:0] LINE2B_FIRST   = 7'h40;
   localparam logic [6:0] LINE2B_LAST    = 7'h67;
   localparam logic [6:0] LINE2B_BASE    = 7'h28;  // Index of 2nd line
   localparam logic [6:0] AC_RESET       = 7'h00;

   // ===============================================================
   // Settings after self-initialisation
   // ===============================================================
   localparam logic       RST_BUS_WIDTH  = 1'b1;   // 8-bit bus
   localparam logic       RST_TWO_LINE   = 1'b0;   // One line
   localparam logic       RST_TALL_FONT  = 1'b0;   // 5 x 8 font
   localparam logic       RST_DISP_ON    = 1'b0;
   localparam logic       RST_CURSOR_ON  = 1'b0;
   localparam logic       RST_BLINK_ON   = 1'b0;
   localparam logic       RST_INC        = 1'b1;   // Increment by one
   localparam logic       RST_SHIFT      = 1'b0;   // No display shift

   // ===============================================================
   // Bus engine states
   // ===============================================================
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_TXACK,
      ST_IGNORE
   } dcr_state_t;

endpackage

// file: design/dcr_ram_if.sv
`timescale 1ns/1ps
// ==================================================================
// Write and read port of the display text RAM
// ==================================================================
interface dcr_ram_if;
   import dcr_pkg::*;
   logic             wr_en;
   logic [AC_W-1:0]  wr_idx;
   logic [7:0]       wr_data;
   logic [AC_W-1:0]  rd_idx;
   logic [7:0]       rd_data;

   modport ctl (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
   modport mem (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

// file: design/dcr_text_ram.sv
`timescale 1ns/1ps
// ==================================================================
// Display text RAM, flip-flop storage
// ==================================================================
module dcr_text_ram
   import dcr_pkg::*;
#(
   parameter int DEPTH = RAM_DEPTH
)
(
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic nrst_in,
   // Memory port
   dcr_ram_if.mem    ram
);

   logic [7:0] mem_q [DEPTH];
   logic [7:0] mem_d [DEPTH];
   logic [7:0] rd_q;
   logic [7:0] rd_d;

   // Next contents; indices past the end are dropped
   always_comb
   begin
      mem_d = mem_q;
      if (ram.wr_en && (int'(ram.wr_idx) < DEPTH))
      begin
         mem_d[ram.wr_idx] = ram.wr_data;
      end
      rd_d = (int'(ram.rd_idx) < DEPTH) ? mem_q[ram.rd_idx] : 8'h00;
   end

   // Storage registers
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= SPACE_CODE;
         end
         rd_q <= 8'h00;
      end
      else
      begin
         mem_q <= mem_d;
         rd_q  <= rd_d;
      end
   end

   assign ram.rd_data = rd_q;

endmodule

// file: design/dcr_i2c_receiver.sv
`timescale 1ns/1ps
// ==================================================================
// Two-wire command receiver of a character display controller
// ==================================================================
module dcr_i2c_receiver
   import dcr_pkg::*;
(
   // Clock and reset
   input  wire logic            core_clk_in,
   input  wire logic            nrst_in,
   // Two-wire bus pins
   input  wire logic            scl_in,
   input  wire logic            sda_in,
   output logic                 sda_out,
   output logic                 sda_oe_n_out,
   // Address straps
   input  wire logic            addr_strap_low_in,
   input  wire logic            addr_strap_high_in,
   // Display refresh read port
   input  wire logic [AC_W-1:0] disp_idx_in,
   output logic [7:0]           disp_data_out,
   // Status and settings
   output logic                 busy_flag_out,
   output logic [AC_W-1:0]      addr_counter_out,
   output logic                 bus_width_select_out,
   output logic                 two_line_out,
   output logic                 tall_font_out,
   output logic                 display_on_out,
   output logic                 cursor_on_out,
   output logic                 blink_on_out,
   output logic                 entry_inc_out,
   output logic                 entry_shift_out
);

   // ===============================================================
   // Pin synchronisers and edge detection
   // ===============================================================
   logic [2:0] scl_q, scl_d;
   logic [2:0] sda_q, sda_d;
   logic [1:0] strap_lo_q, strap_lo_d;
   logic [1:0] strap_hi_q, strap_hi_d;
   logic       scl_rise, scl_fall, start_seen, stop_seen;

   // Two stages, then a third copy for edges
   always_comb
   begin
      scl_d      = {scl_q[1:0], scl_in};
      sda_d      = {sda_q[1:0], sda_in};
      strap_lo_d = {strap_lo_q[0], addr_strap_low_in};
      strap_hi_d = {strap_hi_q[0], addr_strap_high_in};
   end

   // Synchroniser registers, bus pins idle high, straps low
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         scl_q      <= 3'h7;
         sda_q      <= 3'h7;
         strap_lo_q <= 2'h0;
         strap_hi_q <= 2'h0;
      end
      else
      begin
         scl_q      <= scl_d;
         sda_q      <= sda_d;
         strap_lo_q <= strap_lo_d;
         strap_hi_q <= strap_hi_d;
      end
   end

   // Clock edges from stages two and three
   assign scl_rise   = scl_q[1] & ~scl_q[2];
   assign scl_fall   = ~scl_q[1] & scl_q[2];
   assign start_seen = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign stop_seen  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

   // ===============================================================
   // Address counter helpers
   // ===============================================================
   // step up or down with line wrap
   function automatic logic [AC_W-1:0] ac_step(
      input logic [AC_W-1:0] ac,
      input logic            inc,
      input logic            two);
      logic [AC_W-1:0] r;
      r = inc ? ac + 7'h01 : ac - 7'h01;
      if (two)
      begin
         if (inc && ac == LINE2A_LAST)
            r = LINE2B_FIRST;
         else if (inc && ac == LINE2B_LAST)
            r = AC_RESET;
         else if (!inc && ac == LINE2B_FIRST)
            r = LINE2A_LAST;
         else if (!inc && ac == AC_RESET)
            r = LINE2B_LAST;
      end
      else
      begin
         if (inc && ac == LINE1_LAST)
            r = AC_RESET;
         else if (!inc && ac == AC_RESET)
            r = LINE1_LAST;
      end
      return r;
   endfunction

   // Counter value to RAM index
   function automatic logic [AC_W-1:0] ac_index(
      input logic [AC_W-1:0] ac,
      input logic            two);
      logic [AC_W-1:0] r;
      r = ac;
      if (two && ac[6])
         r = {1'b0, ac[5:0]} + LINE2B_BASE;
      return r;
   endfunction

   // ===============================================================
   // Bus engine, settings and initialisation
   // ===============================================================
   dcr_state_t      st_q, st_d;
   logic [3:0]      cnt_q, cnt_d;
   logic [7:0]      sh_q, sh_d;
   logic [7:0]      tx_q, tx_d;
   logic            is_addr_q, is_addr_d;
   logic            rd_mode_q, rd_mode_d;
   logic            exp_ctrl_q, exp_ctrl_d;
   logic            cont_q, cont_d;
   logic            dcs_q, dcs_d;
   logic            mack_q, mack_d;
   logic            drive_q, drive_d;
   logic [1:0]      strap_q, strap_d;
   logic            strap_done_q, strap_done_d;
   logic            fill_q, fill_d;
   logic [AC_W-1:0] fill_idx_q, fill_idx_d;
   logic [AC_W-1:0] ac_q, ac_d;
   logic            dl_q, dl_d, two_q, two_d, tall_q, tall_d;
   logic            don_q, don_d, con_q, con_d, bon_q, bon_d;
   logic            inc_q, inc_d, shf_q, shf_d;
   logic            we_q, we_d;
   logic [AC_W-1:0] widx_q, widx_d;
   logic [7:0]      wdat_q, wdat_d;
   logic [7:0]      rx_byte;

   assign rx_byte = sh_q;

   // Next state of the whole engine
   always_comb
   begin
      st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; tx_d = tx_q;
      is_addr_d = is_addr_q; rd_mode_d = rd_mode_q;
      exp_ctrl_d = exp_ctrl_q; cont_d = cont_q; dcs_d = dcs_q;
      mack_d = mack_q; drive_d = drive_q; strap_d = strap_q;
      strap_done_d = strap_done_q;
      fill_d = fill_q; fill_idx_d = fill_idx_q; ac_d = ac_q;
      dl_d = dl_q; two_d = two_q; tall_d = tall_q;
      don_d = don_q; con_d = con_q; bon_d = bon_q;
      inc_d = inc_q; shf_d = shf_q;
      we_d = 1'b0; widx_d = widx_q; wdat_d = wdat_q;

      if (fill_q)
      begin
         we_d       = 1'b1;
         widx_d     = fill_idx_q;
         wdat_d     = SPACE_CODE;
         fill_idx_d = fill_idx_q + 7'h01;
         if (int'(fill_idx_q) == RAM_DEPTH - 1)
         begin
            fill_d = 1'b0;
            // straps latched once
            // Only the fill after reset, never a clear display
            if (!strap_done_q)
            begin
               strap_d      = {strap_hi_q[1], strap_lo_q[1]};
               strap_done_d = 1'b1;
            end
         end
      end

      case (st_q)
         ST_IDLE, ST_IGNORE:
         begin
            drive_d = 1'b0;
         end
         ST_RX:
         begin
            if (scl_rise)
            begin
               sh_d  = {sh_q[6:0], sda_q[1]};
               cnt_d = cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == 4'h8)
            begin
               if (is_addr_q)
               begin
                  if (rx_byte[7:1] == {ADDR_FIXED_HI, strap_q})
                  begin
                     st_d      = ST_ACK;
                     drive_d   = 1'b1;
                     rd_mode_d = rx_byte[RW_BIT];
                  end
                  else
                  begin
                     st_d = ST_IGNORE;
                  end
               end
               else
               begin
                  st_d    = ST_ACK;
                  drive_d = 1'b1;
                  if (exp_ctrl_q)
                  begin
                     cont_d     = rx_byte[CTRL_CONT_BIT];
                     dcs_d      = rx_byte[CTRL_DCS_BIT];
                     exp_ctrl_d = 1'b0;
                  end
                  else
                  begin
                     exp_ctrl_d = cont_q;
                     if (dcs_q && !fill_q)
                     begin
                        we_d   = 1'b1;
                        widx_d = ac_index(ac_q, two_q);
                        wdat_d = rx_byte;
                        ac_d   = ac_step(ac_q, inc_q, two_q);
                     end
                     else if (!dcs_q && !fill_q)
                     begin
                        casez (rx_byte)
                           8'b1???????: ac_d = rx_byte[6:0];
                           8'b01??????: ac_d = ac_q;
                           8'b001?????:
                           begin
                              dl_d   = rx_byte[4];
                              two_d  = rx_byte[3];
                              tall_d = rx_byte[2];
                           end
                           8'b0001????:
                           begin
                              if (!rx_byte[3])
                                 ac_d = ac_step(ac_q, rx_byte[2], two_q);
                           end
                           8'b00001???:
                           begin
                              don_d = rx_byte[2];
                              con_d = rx_byte[1];
                              bon_d = rx_byte[0];
                           end
                           8'b000001??:
                           begin
                              inc_d = rx_byte[1];
                              shf_d = rx_byte[0];
                           end
                           8'b0000001?: ac_d = AC_RESET;
                           8'b00000001:
                           begin
                              fill_d     = 1'b1;
                              fill_idx_d = AC_RESET;
                              ac_d       = AC_RESET;
                              inc_d      = RST_INC;
                           end
                           default: ac_d = ac_q;
                        endcase
                     end
                  end
               end
            end
         end
         ST_ACK:
         begin
            // hold low until the pulse ends
            if (scl_fall)
            begin
               cnt_d = 4'h0;
               if (is_addr_q && rd_mode_q)
               begin
                  st_d    = ST_TX;
                  tx_d    = {fill_q, ac_q};
                  drive_d = ~fill_q;
               end
               else
               begin
                  st_d    = ST_RX;
                  drive_d = 1'b0;
               end
               is_addr_d = 1'b0;
            end
         end
         ST_TX:
         begin
            // Shift out status byte msb first
            if (scl_rise)
               cnt_d = cnt_q + 4'h1;
            else if (scl_fall)
            begin
               if (cnt_q == 4'h8)
               begin
                  st_d    = ST_TXACK;
                  drive_d = 1'b0;
               end
               else
               begin
                  tx_d    = {tx_q[6:0], 1'b1};
                  drive_d = ~tx_q[6];
               end
            end
         end
         ST_TXACK:
         begin
            if (scl_rise)
               mack_d = ~sda_q[1];
            else if (scl_fall)
            begin
               cnt_d = 4'h0;
               if (mack_q)
               begin
                  st_d    = ST_TX;
                  tx_d    = {fill_q, ac_q};
                  drive_d = ~fill_q;
               end
               else
               begin
                  st_d = ST_IGNORE;
               end
            end
         end
         default:
         begin
            st_d    = ST_IDLE;
            drive_d = 1'b0;
         end
      endcase

      if (start_seen)
      begin
         st_d       = ST_RX;
         cnt_d      = 4'h0;
         is_addr_d  = 1'b1;
         rd_mode_d  = 1'b0;
         exp_ctrl_d = 1'b1;
         cont_d     = 1'b1;
         drive_d    = 1'b0;
      end
      else if (stop_seen)
      begin
         st_d      = ST_IDLE;
         is_addr_d = 1'b1;
         rd_mode_d = 1'b0;
         drive_d   = 1'b0;
      end
   end

   // Engine registers
   // defaults after reset
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_q <= ST_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; tx_q <= 8'hff;
         is_addr_q <= 1'b1; rd_mode_q <= 1'b0;
         exp_ctrl_q <= 1'b1; cont_q <= 1'b1; dcs_q <= 1'b0;
         mack_q <= 1'b0; drive_q <= 1'b0; strap_q <= 2'h0;
         strap_done_q <= 1'b0;
         fill_q <= 1'b1; fill_idx_q <= AC_RESET; ac_q <= AC_RESET;
         dl_q <= RST_BUS_WIDTH; two_q <= RST_TWO_LINE;
         tall_q <= RST_TALL_FONT; don_q <= RST_DISP_ON;
         con_q <= RST_CURSOR_ON; bon_q <= RST_BLINK_ON;
         inc_q <= RST_INC; shf_q <= RST_SHIFT;
         we_q <= 1'b0; widx_q <= AC_RESET; wdat_q <= SPACE_CODE;
      end
      else
      begin
         st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; tx_q <= tx_d;
         is_addr_q <= is_addr_d; rd_mode_q <= rd_mode_d;
         exp_ctrl_q <= exp_ctrl_d; cont_q <= cont_d; dcs_q <= dcs_d;
         mack_q <= mack_d; drive_q <= drive_d; strap_q <= strap_d;
         strap_done_q <= strap_done_d;
         fill_q <= fill_d; fill_idx_q <= fill_idx_d; ac_q <= ac_d;
         dl_q <= dl_d; two_q <= two_d; tall_q <= tall_d;
         don_q <= don_d; con_q <= con_d; bon_q <= bon_d;
         inc_q <= inc_d; shf_q <= shf_d;
         we_q <= we_d; widx_q <= widx_d; wdat_q <= wdat_d;
      end
   end

   // ===============================================================
   // Display text RAM
   // ===============================================================
   dcr_ram_if ram_bus ();

   // Write port from registers, read port from display side
   assign ram_bus.wr_en   = we_q;
   assign ram_bus.wr_idx  = widx_q;
   assign ram_bus.wr_data = wdat_q;
   assign ram_bus.rd_idx  = disp_idx_in;

   dcr_text_ram #(
      .DEPTH (RAM_DEPTH)
   ) u_ram (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .ram         (ram_bus.mem)
   );

   // ===============================================================
   // Outputs
   // ===============================================================
   // Open-drain data pin, enable low while pulling
   assign sda_out              = 1'b0;
   assign sda_oe_n_out         = ~drive_q;
   assign disp_data_out        = ram_bus.rd_data;
   assign busy_flag_out        = fill_q;
   assign addr_counter_out     = ac_q;
   assign bus_width_select_out = dl_q;
   assign two_line_out         = two_q;
   assign tall_font_out        = tall_q;
   assign display_on_out       = don_q;
   assign cursor_on_out        = con_q;
   assign blink_on_out         = bon_q;
   assign entry_inc_out        = inc_q;
   assign entry_shift_out      = shf_q;

endmodule

// file: test/dcr_monitor.sv
`timescale 1ns/1ps
// ==========================================
// Bus pin and start-up checker
// ==========================================
module dcr_monitor
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       nrst_in,
   // Bus pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       sda_out,
   input  wire logic       sda_oe_n_out,
   // Status
   input  wire logic       busy_flag_out,
   input  wire logic [7:0] disp_data_out
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic       scl_p_q, sda_p_q, rd_q, rd_d;
   logic [3:0] nbit_q, nbit_d;

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   // Cycles since reset release, saturating
   always_comb cnt_d = (cnt_q == 7'h7f) ? cnt_q : cnt_q + 7'h01;

   // Counter register
   always_ff @(posedge core_clk_in or negedge nrst_in)
      if (!nrst_in)
         cnt_q <= 7'h00;
      else
         cnt_q <= cnt_d;

   // Direction bit of the address byte
   always_comb
   begin
      nbit_d = nbit_q;
      rd_d   = rd_q;
      if (scl_in && scl_p_q && !sda_in && sda_p_q)
      begin
         nbit_d = 4'h0;
         rd_d   = 1'b0;
      end
      else if (scl_in && !scl_p_q && nbit_q != 4'hf)
      begin
         nbit_d = nbit_q + 4'h1;
         rd_d   = (nbit_q == 4'h7) ? sda_in : rd_q;
      end
   end

   // Tracker registers, bus idle high
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         nbit_q  <= 4'hf;
         rd_q    <= 1'b0;
      end
      else
      begin
         scl_p_q <= scl_in;
         sda_p_q <= sda_in;
         nbit_q  <= nbit_d;
         rd_q    <= rd_d;
      end
   end

   sda_zero_a: assert property (sda_out == 1'b0)
      else $error("sda drive value not zero");
   busy_init_a: assert property (cnt_q < 7'h4e |-> busy_flag_out)
      else $error("busy low during init");
   busy_end_a: assert property (cnt_q == 7'h5a |-> !busy_flag_out)
      else $error("busy still high after init");
   disp_init_a: assert property
      (cnt_q > 7'h04 && cnt_q < 7'h4e |-> disp_data_out == 8'h20)
      else $error("ram not spaces during init");
   ack_stable_a: assert property
      (scl_in && $past(scl_in) |-> $stable(sda_oe_n_out))
      else $error("drive changed with clock high");
   ack_len_a: assert property
      ($fell(sda_oe_n_out) && !rd_q |->
         !sda_oe_n_out [*4] ##[1:12] sda_oe_n_out)
      else $error("ack drive length wrong");
   start_quiet_a: assert property
      (scl_in && $fell(sda_in) |-> sda_oe_n_out [*8])
      else $error("driving at start");
   stop_quiet_a: assert property
      (scl_in && $rose(sda_in) |-> sda_oe_n_out [*8])
      else $error("driving at stop");
endmodule

bind dcr_i2c_receiver dcr_monitor u_mon (.core_clk_in, .nrst_in,
   .scl_in, .sda_in, .sda_out, .sda_oe_n_out, .busy_flag_out,
   .disp_data_out);

// file: test/dcr_bus_master.sv
`timescale 1ns/1ps
// ==========================================
// Two-wire bus master model
// ==========================================
module dcr_bus_master
(
   // Clock
   input  wire logic core_clk_in,
   // Bus lines
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   task automatic w(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   task automatic start();
      sda_out <= 1'b1;
      w(3);
      scl_out <= 1'b1;
      w(2);
      sda_out <= 1'b0;
      w(2);
      scl_out <= 1'b0;
      w(2);
   endtask

   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sda_out <= b[i];
         w(3);
         scl_out <= 1'b1;
         w(3);
         scl_out <= 1'b0;
         w(2);
      end
      sda_out <= 1'b1;
      w(3);
      scl_out <= 1'b1;
      w(2);
      ack = !sda_in;
      w(1);
      scl_out <= 1'b0;
      w(2);
   endtask

   // read a byte, then ack or withhold
   task automatic recv(input logic ack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         w(3);
         scl_out <= 1'b1;
         w(2);
         b[i] = sda_in;
         w(1);
         scl_out <= 1'b0;
         w(2);
      end
      sda_out <= !ack;
      w(3);
      scl_out <= 1'b1;
      w(3);
      scl_out <= 1'b0;
      w(2);
      sda_out <= 1'b1;
      w(1);
   endtask

   task automatic stop();
      sda_out <= 1'b0;
      w(3);
      scl_out <= 1'b1;
      w(3);
      sda_out <= 1'b1;
      w(3);
   endtask
endmodule

// file: test/dcr_i2c_receiver_tb.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench of the receiver
// ==========================================
module dcr_i2c_receiver_tb
   import dcr_pkg::*;
;
   logic            clk = 1'b0;
   logic            nrst = 1'b0;
   logic            s_lo = 1'b0;
   logic            s_hi = 1'b0;
   logic [AC_W-1:0] idx = 7'h00;
   logic [AC_W-1:0] ac;
   logic [7:0]      disp;
   logic            scl, m_sda, oe_n, d_sda, busy;
   logic            dl, two, tall, don, con, bon, inc, sh;
   int              fails = 0;
   int              comparisons = 0;
   wire logic       sda = m_sda & (oe_n | d_sda);

   // Clock
   always #25 clk = ~clk;

   // Units under test
   // no chip select pin, tied low on board
   dcr_bus_master m (.core_clk_in(clk), .sda_in(sda), .scl_out(scl),
      .sda_out(m_sda));
   dcr_i2c_receiver u_dut (.core_clk_in(clk), .nrst_in(nrst),
      .scl_in(scl), .sda_in(sda), .sda_out(d_sda), .sda_oe_n_out(oe_n),
      .addr_strap_low_in(s_lo), .addr_strap_high_in(s_hi),
      .disp_idx_in(idx), .disp_data_out(disp), .busy_flag_out(busy),
      .addr_counter_out(ac), .bus_width_select_out(dl),
      .two_line_out(two), .tall_font_out(tall), .display_on_out(don),
      .cursor_on_out(con), .blink_on_out(bon), .entry_inc_out(inc),
      .entry_shift_out(sh));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] s);
      int n;
      n = 0;
      nrst <= 1'b0;
      {s_hi, s_lo} <= s;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      while (busy !== 1'b0 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 200)
      begin
         fails++;
         give_verdict();
      end
   endtask

   task automatic xfer(input logic [7:0] b, input logic exp);
      logic a;
      m.send(b, a);
      check({7'h00, a}, {7'h00, exp});
   endtask

   task automatic peek(input logic [6:0] i, input logic [7:0] exp);
      idx <= i;
      repeat (2) @(posedge clk);
      check(disp, exp);
   endtask

   task automatic t_init();
      check({dl, two, tall, 5'h00}, 8'h80);
      check({don, con, bon, 5'h00}, 8'h00);
      check({inc, sh, 6'h00}, 8'h80);
      for (int i = 0; i < 80; i++)
         peek(i[6:0], 8'h20);
      $display("t_init done");
   endtask

   task automatic t_write();
      m.start();
      xfer(8'h78, 1'b1);
      xfer(8'hc0, 1'b1);
      xfer(8'h41, 1'b1);
      xfer(8'h40, 1'b1);
      xfer(8'h42, 1'b1);
      xfer(8'h43, 1'b1);
      m.stop();
      peek(7'h00, 8'h41);
      peek(7'h01, 8'h42);
      peek(7'h02, 8'h43);
      check({1'b0, ac}, 8'h03);
      $display("t_write done");
   endtask

   task automatic t_cmd();
      m.start();
      xfer(8'h78, 1'b1);
      xfer(8'h80, 1'b1);
      xfer(8'h0c, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'h38, 1'b1);
      xfer(8'h04, 1'b1);
      xfer(8'h85, 1'b1);
      m.stop();
      check({dl, two, tall, don, con, bon, inc, sh}, 8'hd0);
      check({1'b0, ac}, 8'h05);
      m.start();
      xfer(8'h78, 1'b1);
      xfer(8'h40, 1'b1);
      xfer(8'h5a, 1'b1);
      m.stop();
      peek(7'h05, 8'h5a);
      check({1'b0, ac}, 8'h04);
      $display("t_cmd done");
   endtask

   task automatic t_ignore();
      m.start();
      xfer(8'h7a, 1'b0);
      xfer(8'h40, 1'b0);
      xfer(8'h66, 1'b0);
      m.stop();
      peek(7'h04, 8'h20);
      check({1'b0, ac}, 8'h04);
      $display("t_ignore done");
   endtask

   task automatic t_read();
      logic [7:0] b;
      m.start();
      xfer(8'h78, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'h14, 1'b1);
      m.start();
      xfer(8'h79, 1'b1);
      m.recv(1'b1, b);
      check(b, 8'h05);
      m.recv(1'b0, b);
      check(b, 8'h05);
      m.recv(1'b0, b);
      check(b, 8'hff);
      m.stop();
      m.start();
      xfer(8'h78, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'h01, 1'b1);
      m.stop();
      check({7'h00, busy}, 8'h01);
      repeat (80) @(posedge clk);
      check({busy, inc, 6'h00}, 8'h40);
      check({1'b0, ac}, 8'h00);
      peek(7'h05, 8'h20);
      $display("t_read done");
   endtask

   task automatic t_strap();
      for (int s = 0; s < 4; s++)
      begin
         do_reset(s[1:0]);
         {s_hi, s_lo} <= ~s[1:0];
         m.start();
         xfer({5'h0f, ~s[1:0], 1'b0}, 1'b0);
         m.stop();
         m.start();
         xfer({5'h0f, s[1:0], 1'b0}, 1'b1);
         m.stop();
      end
      $display("t_strap done");
   endtask

   // Main sequence
   initial
   begin
      do_reset(2'h0);
      t_init();
      t_write();
      t_cmd();
      t_ignore();
      t_read();
      t_strap();
      give_verdict();
   end
endmodule
